/* File: logic/pwr_seq_device.sv */
/*
  Module-side power sequencer: measures low time on the power key and the
  hard reset line, runs power-on, orderly power-down (network deregister
  then shutdown), software shutdown and hard reset.
  Assumes control line levels synchronous to clock; deregistration length
  is reported by the network stack through dereg_done.
*/
// Functional notes
// R1: Key low 2 s while off powers on
// R2: Host waits 30 ms after supply rise
// R3: Key low 3 s then release powers down
// R4: Software shutdown command does orderly power-down
// R5: Key held low blocks software shutdown
// R6: Host cuts supply only after shutdown completes
// R7: Power-down deregisters first, variable duration
// R8: Reset low 100 ms then release restarts
// R9: Host uses hard reset only as fallback
// R10: Key tied low powers on automatically
// R11: Short key pulses leave power state unchanged
module pwr_seq_device #(
  parameter longint unsigned ON_HOLD = pwr_seq_pkg::ON_HOLD_CYCLES,
  parameter longint unsigned OFF_HOLD = pwr_seq_pkg::OFF_HOLD_CYCLES,
  parameter longint unsigned RESET_HOLD = pwr_seq_pkg::RESET_HOLD_CYCLES,
  parameter int CNT_W = 32
) (
  // Clock and supply reset
  input wire logic clock,
  input wire logic reset,
  // Control lines
  pwr_ctrl_if.device ctrl,
  // Module core side
  input wire logic software_shutdown_command,
  input wire logic dereg_done,
  output logic powered_on,
  output logic dereg_active,
  output logic core_reset,
  output logic shutdown_done,
  output pwr_seq_pkg::power_state_e power_state
);

  // Refuse holds the counters cannot reach; the key counter stops at the
  // off hold, so an on hold above it could never be met
  if (CNT_W < 1 || CNT_W > 63 || ON_HOLD < 1 || OFF_HOLD < 1 || RESET_HOLD < 1 ||
      ON_HOLD > OFF_HOLD || OFF_HOLD >= (64'h1 << CNT_W) ||
      RESET_HOLD >= (64'h1 << CNT_W)) begin : g_bad_holds
    $error("pwr_seq_device: hold counts do not fit counter");
  end

  localparam logic [CNT_W-1:0] ON_LIM = CNT_W'(ON_HOLD);
  localparam logic [CNT_W-1:0] OFF_LIM = CNT_W'(OFF_HOLD);
  localparam logic [CNT_W-1:0] RST_LIM = CNT_W'(RESET_HOLD);

  pwr_seq_pkg::power_state_e state_q;
  logic [CNT_W-1:0] key_cnt_q;
  logic [CNT_W-1:0] rst_cnt_q;
  logic key_low;
  logic rst_low;
  logic key_on_met;
  logic key_off_met;
  logic rst_met;
  logic key_armed_q;
  logic rst_armed_q;
  logic key_release_off;
  logic rst_release;

  // ----------------------------------------------------------------------
  // Low-time measurement
  // ----------------------------------------------------------------------
  assign key_low = ~ctrl.power_key_n;
  assign rst_low = ~ctrl.hard_reset_n;
  assign key_on_met = key_cnt_q >= ON_LIM;
  assign key_off_met = key_cnt_q >= OFF_LIM;
  assign rst_met = rst_cnt_q >= RST_LIM;

  // Saturating key counter; cleared on release so short pulses are lost
  always_ff @(posedge clock) begin
    if (reset || !key_low) begin
      key_cnt_q <= '0; // R11
    end else if (!key_off_met) begin
      key_cnt_q <= key_cnt_q + CNT_W'(1);
    end
  end

  // Saturating reset-line counter
  always_ff @(posedge clock) begin
    if (reset || !rst_low) begin
      rst_cnt_q <= '0;
    end else if (!rst_met) begin
      rst_cnt_q <= rst_cnt_q + CNT_W'(1);
    end
  end

  // Off request is armed by a long hold taken while running
  always_ff @(posedge clock) begin
    if (reset) begin
      key_armed_q <= 1'b0;
    end else if (state_q != pwr_seq_pkg::ST_ON) begin
      key_armed_q <= 1'b0;
    end else if (key_low && key_off_met) begin
      key_armed_q <= 1'b1;
    end
  end

  // Reset request is armed by a long hold, acted on at release
  always_ff @(posedge clock) begin
    if (reset) begin
      rst_armed_q <= 1'b0;
    end else if (!rst_low) begin
      rst_armed_q <= 1'b0;
    end else if (rst_met) begin
      rst_armed_q <= 1'b1;
    end
  end

  assign key_release_off = key_armed_q && !key_low; // R3
  assign rst_release = rst_armed_q && !rst_low; // R8

  // ----------------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------------
  // Off from supply reset; a key tied low satisfies the on hold by itself
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= pwr_seq_pkg::ST_OFF;
    end else if (rst_release && state_q != pwr_seq_pkg::ST_OFF) begin
      state_q <= pwr_seq_pkg::ST_RESET; // R8
    end else begin
      case (state_q)
        pwr_seq_pkg::ST_OFF: begin
          if (key_low && key_on_met) begin
            state_q <= pwr_seq_pkg::ST_ON; // R1 R10
          end
        end
        pwr_seq_pkg::ST_ON: begin
          // A key held low vetoes the software command
          if (key_release_off) begin
            state_q <= pwr_seq_pkg::ST_DEREG; // R3
          end else if (software_shutdown_command && !key_low) begin
            state_q <= pwr_seq_pkg::ST_DEREG; // R4 R5
          end
        end
        pwr_seq_pkg::ST_DEREG: begin
          // Duration set by the network, so no timeout here
          if (dereg_done) begin
            state_q <= pwr_seq_pkg::ST_SHUTDOWN; // R7
          end
        end
        pwr_seq_pkg::ST_SHUTDOWN: begin
          state_q <= pwr_seq_pkg::ST_OFF;
        end
        pwr_seq_pkg::ST_RESET: begin
          state_q <= pwr_seq_pkg::ST_ON;
        end
        default: begin
          state_q <= pwr_seq_pkg::ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Registered status, one cycle behind the state
  always_ff @(posedge clock) begin
    if (reset) begin
      powered_on <= 1'b0;
      dereg_active <= 1'b0;
      core_reset <= 1'b0;
      shutdown_done <= 1'b0;
      power_state <= pwr_seq_pkg::ST_OFF;
    end else begin
      powered_on <= state_q == pwr_seq_pkg::ST_ON;
      dereg_active <= state_q == pwr_seq_pkg::ST_DEREG; // R7
      core_reset <= state_q == pwr_seq_pkg::ST_RESET; // R8
      shutdown_done <= state_q == pwr_seq_pkg::ST_SHUTDOWN;
      power_state <= state_q;
    end
  end

endmodule : pwr_seq_device

/* File: logic/pwr_seq_pkg.sv */
/*
  Shared constants for the power key and hard reset sequencer: hold times,
  clock rate and derived cycle counts, and the device power states.
  Assumes a single 250 MHz clock shared by both ends.
*/
package pwr_seq_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam longint unsigned CLOCK_HZ = 250000000;
  localparam longint unsigned ON_HOLD_MS = 2000;       // Least key hold to turn on
  localparam longint unsigned OFF_HOLD_MS = 3000;      // Least key hold to turn off
  localparam longint unsigned RESET_HOLD_MS = 100;     // Least reset hold
  localparam longint unsigned SUPPLY_SETTLE_MS = 30;   // Supply settle before key

  // Least times round up to whole cycles
  localparam longint unsigned ON_HOLD_CYCLES = (ON_HOLD_MS * CLOCK_HZ + 999) / 1000;
  localparam longint unsigned OFF_HOLD_CYCLES = (OFF_HOLD_MS * CLOCK_HZ + 999) / 1000;
  localparam longint unsigned RESET_HOLD_CYCLES = (RESET_HOLD_MS * CLOCK_HZ + 999) / 1000;
  localparam longint unsigned SETTLE_CYCLES = (SUPPLY_SETTLE_MS * CLOCK_HZ + 999) / 1000;

  // Default time spent deregistering from the network
  localparam longint unsigned DEREG_CYCLES = 1000;

  // ----------------------------------------------------------------------
  // Device power states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_ON = 3'b001,
    ST_DEREG = 3'b010,
    ST_SHUTDOWN = 3'b011,
    ST_RESET = 3'b100
  } power_state_e;

endpackage : pwr_seq_pkg

/* File: logic/pwr_ctrl_if.sv */
/*
  Control lines between the host and the module: active-low power key and
  hard reset, both open drain. The module side sees the resolved levels.
  Assumes external pull-ups, modelled here as the idle high level.
*/
interface pwr_ctrl_if;
  // Host drive enables (pull low while high)
  logic power_key_oe;
  logic hard_reset_oe;
  // Resolved line levels, high when nobody pulls low
  logic power_key_n;
  logic hard_reset_n;

  assign power_key_n = ~power_key_oe;
  assign hard_reset_n = ~hard_reset_oe;

  modport host (output power_key_oe, output hard_reset_oe);
  modport device (input power_key_n, input hard_reset_n);
endinterface : pwr_ctrl_if

/* File: logic/pwr_seq_host.sv */
/*
  Host-side driver of the power key and hard reset lines: waits for the
  supply to settle, then issues timed low pulses on request.
  Assumes requests arrive as one-cycle pulses and the host never cuts the
  supply itself; supply removal is its system's job after shutdown.
*/
module pwr_seq_host #(
  parameter longint unsigned ON_HOLD = pwr_seq_pkg::ON_HOLD_CYCLES,
  parameter longint unsigned OFF_HOLD = pwr_seq_pkg::OFF_HOLD_CYCLES,
  parameter longint unsigned RESET_HOLD = pwr_seq_pkg::RESET_HOLD_CYCLES,
  parameter longint unsigned SETTLE = pwr_seq_pkg::SETTLE_CYCLES,
  parameter int CNT_W = 32
) (
  // Clock and reset (supply rise)
  input wire logic clock,
  input wire logic reset,
  // User requests
  input wire logic turn_on_req,
  input wire logic turn_off_req,
  input wire logic hard_reset_req,
  output logic busy,
  output logic settled,
  // Control lines
  pwr_ctrl_if.host ctrl
);

  // Every pulse length and the settle wait must fit the one counter
  if (CNT_W < 1 || CNT_W > 63 || ON_HOLD < 1 || OFF_HOLD < 1 || RESET_HOLD < 1 ||
      SETTLE < 1 || ON_HOLD >= (64'h1 << CNT_W) || OFF_HOLD >= (64'h1 << CNT_W) ||
      RESET_HOLD >= (64'h1 << CNT_W) || SETTLE >= (64'h1 << CNT_W)) begin : g_bad_counts
    $error("pwr_seq_host: counts do not fit counter");
  end

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_KEY = 2'b01,
    H_RST = 2'b10
  } host_state_e;

  host_state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] len_q;

  // ----------------------------------------------------------------------
  // Supply settle wait
  // ----------------------------------------------------------------------
  // No key pulse until the supply has stood stable
  always_ff @(posedge clock) begin
    if (reset) begin
      settled <= 1'b0;
    end else if (state_q == H_IDLE && cnt_q >= CNT_W'(SETTLE)) begin
      settled <= 1'b1; // R2
    end
  end

  // ----------------------------------------------------------------------
  // Pulse sequencer
  // ----------------------------------------------------------------------
  // Hard reset is offered as a separate request, meant as last resort
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= H_IDLE;
      cnt_q <= '0;
      len_q <= '0;
    end else begin
      case (state_q)
        H_IDLE: begin
          if (!settled) begin
            cnt_q <= cnt_q + CNT_W'(1);
          end else if (hard_reset_req) begin
            state_q <= H_RST; // R9
            cnt_q <= '0;
            len_q <= CNT_W'(RESET_HOLD); // R8
          end else if (turn_off_req) begin
            state_q <= H_KEY;
            cnt_q <= '0;
            len_q <= CNT_W'(OFF_HOLD); // R3
          end else if (turn_on_req) begin
            state_q <= H_KEY;
            cnt_q <= '0;
            len_q <= CNT_W'(ON_HOLD); // R1
          end
        end
        H_KEY, H_RST: begin
          if (cnt_q + CNT_W'(1) >= len_q) begin
            state_q <= H_IDLE;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  // Open-drain drive: enable high pulls the line low
  assign ctrl.power_key_oe = state_q == H_KEY;
  assign ctrl.hard_reset_oe = state_q == H_RST;
  assign busy = state_q != H_IDLE || !settled;

endmodule : pwr_seq_host

/* File: sim/pwr_seq_props.sv */
/*
  Checker for the key and reset line sequencing at the device end.
  Assumes one clock and the device hold counts as parameters.
*/
module pwr_seq_props #(
  parameter int ON_HOLD = 20,
  parameter int OFF_HOLD = 30,
  parameter int RESET_HOLD = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Control lines
  input wire logic power_key_n,
  input wire logic hard_reset_n,
  // Device outputs
  input wire logic core_reset,
  input wire logic dereg_active,
  input wire logic shutdown_done,
  input wire pwr_seq_pkg::power_state_e power_state
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // Low time counters
  // ----------------------------------------------------------------------
  logic [15:0] key_low_q;
  logic [15:0] rst_low_q;

  // Cleared on release, so a value seen at release is the whole press
  always_ff @(posedge clock) begin
    key_low_q <= (reset || power_key_n) ? 16'h0000 : key_low_q + 16'h0001;
  end
  // Same measure for the reset line
  always_ff @(posedge clock) begin
    rst_low_q <= (reset || hard_reset_n) ? 16'h0000 : rst_low_q + 16'h0001;
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_short_key_off: assert property (
    power_state == pwr_seq_pkg::ST_OFF && int'(key_low_q) + 2 < ON_HOLD
    |=> power_state == pwr_seq_pkg::ST_OFF) else $error("short press left off");
  a_long_key_on: assert property (
    power_state == pwr_seq_pkg::ST_OFF && !power_key_n && int'(key_low_q) == ON_HOLD
    |-> ##[0:2] power_state == pwr_seq_pkg::ST_ON) else $error("no power on");
  a_on_exit_dereg: assert property (
    power_state == pwr_seq_pkg::ST_ON |=> power_state inside
    {pwr_seq_pkg::ST_ON, pwr_seq_pkg::ST_DEREG, pwr_seq_pkg::ST_RESET}) else $error("bad exit");
  a_dereg_exit: assert property (
    power_state == pwr_seq_pkg::ST_DEREG |-> dereg_active ##1 power_state inside
    {pwr_seq_pkg::ST_DEREG, pwr_seq_pkg::ST_SHUTDOWN, pwr_seq_pkg::ST_RESET})
    else $error("bad deregister step");
  a_shutdown_pulse: assert property (
    power_state == pwr_seq_pkg::ST_SHUTDOWN |-> shutdown_done ##1 (!shutdown_done &&
    power_state inside {pwr_seq_pkg::ST_OFF, pwr_seq_pkg::ST_RESET}))
    else $error("bad shutdown end");
  a_key_veto: assert property (
    !power_key_n ##1 power_state == pwr_seq_pkg::ST_ON
    |=> power_state != pwr_seq_pkg::ST_DEREG) else $error("off while key low");
  a_key_release_off: assert property (
    power_state == pwr_seq_pkg::ST_ON && power_key_n && int'(key_low_q) > OFF_HOLD
    |-> ##[1:3] power_state == pwr_seq_pkg::ST_DEREG) else $error("no power down");
  a_reset_release: assert property (
    power_state == pwr_seq_pkg::ST_ON && hard_reset_n && int'(rst_low_q) > RESET_HOLD
    |-> ##[1:3] power_state == pwr_seq_pkg::ST_RESET) else $error("no reset");
  a_reset_pulse: assert property (
    power_state == pwr_seq_pkg::ST_RESET |-> core_reset
    ##1 (power_state == pwr_seq_pkg::ST_ON && !core_reset)) else $error("bad reset pulse");
endmodule : pwr_seq_props

/* File: sim/power_key_reset_sequencer_test.sv */
/*
  Bench: host and device ends joined; a second pair with short host
  holds must stay off after each turn-on press. Assumes the hand-over timing walks.
*/
module power_key_reset_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DON = 20;
  localparam int DOFF = 30;
  localparam int DRST = 10;
  logic clock, reset, turn_on_req, turn_off_req, hard_reset_req, busy, settled;
  logic software_shutdown_command, dereg_done, powered_on, dereg_active;
  logic core_reset, shutdown_done;
  pwr_seq_pkg::power_state_e power_state, state_b, state_c;
  int err_count = 0;
  int samples_checked = 0;
  pwr_ctrl_if ctrl_a ();
  pwr_ctrl_if ctrl_b ();
  pwr_ctrl_if ctrl_c ();

  // Host holds one cycle past the device hold count, the least low time the device acts on
  pwr_seq_host #(.ON_HOLD(DON + 1), .OFF_HOLD(DOFF + 1), .RESET_HOLD(DRST + 1), .SETTLE(5))
    pwr_seq_host_i (.clock(clock), .reset(reset), .turn_on_req(turn_on_req),
    .turn_off_req(turn_off_req), .hard_reset_req(hard_reset_req), .busy(busy),
    .settled(settled), .ctrl(ctrl_a));
  pwr_seq_device #(.ON_HOLD(DON), .OFF_HOLD(DOFF), .RESET_HOLD(DRST)) pwr_seq_device_i (
    .clock(clock), .reset(reset), .ctrl(ctrl_a), .software_shutdown_command(software_shutdown_command),
    .dereg_done(dereg_done), .powered_on(powered_on), .dereg_active(dereg_active),
    .core_reset(core_reset), .shutdown_done(shutdown_done), .power_state(power_state));
  // Short pair: presses two cycles below the device hold count
  pwr_seq_host #(.ON_HOLD(DON - 2), .OFF_HOLD(DOFF - 2), .RESET_HOLD(DRST - 2), .SETTLE(5))
    pwr_seq_host_b_i (.clock(clock), .reset(reset), .turn_on_req(turn_on_req),
    .turn_off_req(turn_off_req), .hard_reset_req(hard_reset_req), .busy(),
    .settled(), .ctrl(ctrl_b));
  pwr_seq_device #(.ON_HOLD(DON), .OFF_HOLD(DOFF), .RESET_HOLD(DRST)) pwr_seq_device_b_i (
    .clock(clock), .reset(reset), .ctrl(ctrl_b), .software_shutdown_command(1'b0),
    .dereg_done(1'b0), .powered_on(), .dereg_active(), .core_reset(), .shutdown_done(),
    .power_state(state_b));
  // Key tied low: powers on by itself and must refuse every command
  pwr_seq_device #(.ON_HOLD(DON), .OFF_HOLD(DOFF), .RESET_HOLD(DRST)) pwr_seq_device_c_i (
    .clock(clock), .reset(reset), .ctrl(ctrl_c),
    .software_shutdown_command(software_shutdown_command), .dereg_done(dereg_done),
    .powered_on(), .dereg_active(), .core_reset(), .shutdown_done(), .power_state(state_c));
  pwr_seq_props #(.ON_HOLD(DON), .OFF_HOLD(DOFF), .RESET_HOLD(DRST)) pwr_seq_props_i (
    .clock(clock), .reset(reset), .power_key_n(ctrl_a.power_key_n),
    .hard_reset_n(ctrl_a.hard_reset_n), .core_reset(core_reset), .dereg_active(dereg_active),
    .shutdown_done(shutdown_done), .power_state(power_state));

  // Clock, 4 ns period
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit
  task automatic check_state(input string nm, input pwr_seq_pkg::power_state_e e,
                             input pwr_seq_pkg::power_state_e g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : check_state
  task automatic results;
    $display("Checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  // Sample 1 ns after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // One-cycle request: 0 on, 1 off, 2 reset, 3 command, 4 deregistered
  task automatic pulse(input int k);
    @(posedge clock);
    {dereg_done, software_shutdown_command, hard_reset_req, turn_off_req, turn_on_req} <=
      5'h01 << k;
    @(posedge clock);
    {dereg_done, software_shutdown_command, hard_reset_req, turn_off_req, turn_on_req} <= 5'h00;
    #1;
  endtask : pulse
  task automatic wait_state(input string nm, input pwr_seq_pkg::power_state_e s, input int n);
    for (int i = 0; i < n && power_state !== s; i++) tick(1);
    check_state(nm, s, power_state);
    if (power_state !== s) results();
  endtask : wait_state
  task automatic wait_idle;
    tick(1);
    for (int i = 0; i < 200 && busy !== 1'b0; i++) tick(1);
    check_bit("host idle", 1'b0, busy);
    if (busy !== 1'b0) results();
  endtask : wait_idle
  task automatic finish_dereg(input string nm);
    pulse(4);
    wait_state(nm, pwr_seq_pkg::ST_SHUTDOWN, 5);
    check_bit("shutdown_done", 1'b1, shutdown_done);
    check_bit("dereg_active", 1'b0, dereg_active);
    tick(1);
    check_state("off after shutdown", pwr_seq_pkg::ST_OFF, power_state);
    check_bit("shutdown_done low", 1'b0, shutdown_done);
  endtask : finish_dereg

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic power_on_test;
    pulse(0);
    wait_state("power on", pwr_seq_pkg::ST_ON, 40);
    tick(1);
    check_bit("powered_on", 1'b1, powered_on);
    wait_idle();
    check_state("brief press", pwr_seq_pkg::ST_OFF, state_b);
    check_state("tied key on", pwr_seq_pkg::ST_ON, state_c);
  endtask : power_on_test
  task automatic short_press_test;
    pulse(0);
    wait_idle();
    tick(5);
    check_state("short press", pwr_seq_pkg::ST_ON, power_state);
  endtask : short_press_test
  task automatic sw_shutdown_test;
    pulse(3);
    wait_state("command", pwr_seq_pkg::ST_DEREG, 5);
    check_state("tied key veto", pwr_seq_pkg::ST_ON, state_c);
    tick(1);
    check_bit("dereg_active", 1'b1, dereg_active);
    tick(20);
    check_state("network wait", pwr_seq_pkg::ST_DEREG, power_state);
    finish_dereg("command off");
  endtask : sw_shutdown_test
  task automatic reset_off_test;
    pulse(2);
    wait_idle();
    tick(3);
    check_state("reset while off", pwr_seq_pkg::ST_OFF, power_state);
  endtask : reset_off_test
  task automatic hard_reset_test;
    pulse(2);
    wait_state("hard reset", pwr_seq_pkg::ST_RESET, 30);
    check_bit("core_reset", 1'b1, core_reset);
    tick(1);
    check_state("after reset", pwr_seq_pkg::ST_ON, power_state);
    check_bit("core_reset low", 1'b0, core_reset);
  endtask : hard_reset_test
  task automatic key_off_test;
    pulse(1);
    tick(5);
    pulse(3);
    tick(3);
    check_state("command vetoed", pwr_seq_pkg::ST_ON, power_state);
    wait_state("key off", pwr_seq_pkg::ST_DEREG, 40);
    finish_dereg("key off done");
  endtask : key_off_test
  // Supply rise: reset released at an edge, then the host must settle
  task automatic release_supply;
    @(posedge clock);
    reset <= 1'b0;
    tick(1);
    check_bit("key idle", 1'b1, ctrl_a.power_key_n);
    for (int i = 0; i < 20 && settled !== 1'b1; i++) tick(1);
    check_bit("settled", 1'b1, settled);
    if (settled !== 1'b1) results();
  endtask : release_supply
  // Supply cut only once shutdown has finished, then restored
  task automatic supply_cut_test;
    @(posedge clock);
    reset <= 1'b1;
    tick(4);
    check_state("supply cut", pwr_seq_pkg::ST_OFF, power_state);
    check_bit("settled cleared", 1'b0, settled);
    check_bit("host busy", 1'b1, busy);
    release_supply();
    check_state("off after supply", pwr_seq_pkg::ST_OFF, power_state);
  endtask : supply_cut_test

  // Main sequence
  initial begin
    reset = 1'b1;
    {dereg_done, software_shutdown_command, hard_reset_req, turn_off_req, turn_on_req} = 5'h00;
    ctrl_c.power_key_oe = 1'b1;
    ctrl_c.hard_reset_oe = 1'b0;
    repeat (3) @(posedge clock);
    release_supply();
    power_on_test();
    short_press_test();
    sw_shutdown_test();
    reset_off_test();
    power_on_test();
    hard_reset_test();
    key_off_test();
    supply_cut_test();
    power_on_test();
    results();
  end
endmodule : power_key_reset_sequencer_test
